// file: rtl/bccc_defines.svh
`ifndef BCCC_DEFINES_SVH
`define BCCC_DEFINES_SVH

// register byte offsets; pages of eight channel words share bits [11:5]
`define BCCC_PAGE_BUF 7'h00
`define BCCC_PAGE_ACT 7'h01
`define BCCC_OFF_BCAST 12'h040
`define BCCC_OFF_TRIG 12'h044
`define BCCC_OFF_SYNC 12'h048
`define BCCC_OFF_PWR 12'h04c
`define BCCC_OFF_LIMIT 12'h050
`define BCCC_OFF_CURR 12'h054
`define BCCC_OFF_PSTAT 12'h058
`define BCCC_OFF_ALARM 12'h05c
`define BCCC_OFF_APD 12'h060
`define BCCC_OFF_MFCFG 12'h064

// field positions
`define BCCC_TRIG_DAC_POS 0
`define BCCC_SYNC_MEMBER_POS 8
`define BCCC_LIMIT_EN_POS 8
`define BCCC_MF_LOAD_POS 0

// reset values and limit constants
`define BCCC_RST_CODE 13'h0000
`define BCCC_RST_LIMIT 6'h3f
`define BCCC_RST_PWR 8'h00
`define BCCC_RST_RANGE_NEG 2'h3
`define BCCC_LIMIT_FULL 6'h3f
`define BCCC_LIMIT_LOW_FILL 7'h7f

// timing: edges after reset release before the range snapshot
`define BCCC_STARTUP_CYC 3'h4

// analog transfer: vout = code / 2^13 * span + vmin, in millivolts
`define BCCC_FSR_MV 10000
`define BCCC_VMIN_POS_MV 0
`define BCCC_VMIN_NEG_MV -10000

`endif

// file: rtl/bccc_pkg.sv
package bccc_pkg;
	typedef enum logic [1:0] {
		BCCC_CUR_LOW = 2'b00,
		BCCC_CUR_NORMAL = 2'b01,
		BCCC_CUR_HIGH = 2'b10
	} bccc_cur_t;
	typedef enum logic [1:0] {
		BCCC_SUP_INVALID = 2'b00,
		BCCC_SUP_POS = 2'b01,
		BCCC_SUP_NEG = 2'b10
	} bccc_class_t;
	typedef enum logic [1:0] {
		BCCC_OKAY = 2'b00,
		BCCC_SLVERR = 2'b10
	} bccc_resp_t;
endpackage

// file: rtl/bccc_supply_class.sv
`timescale 1ns/1ps
module bccc_supply_class
	import bccc_pkg::*;
(
	input wire logic clk_in, // clock
	input wire logic reset_in, // synchronous reset
	input wire logic [3:0] cmp_in, // {vss_ok, vss_zero, vcc_ok, vcc_zero}
	output bccc_class_t class_out // registered classification
);
	bccc_class_t class_ff;
	bccc_class_t nxt_class;

	// vcc_ok: 3v..11v, vss_ok: -11v..-3v
	always_comb begin
		nxt_class = BCCC_SUP_INVALID;
		if (cmp_in[1] && cmp_in[2]) begin
			nxt_class = BCCC_SUP_POS;
		end else if (cmp_in[0] && cmp_in[3]) begin
			nxt_class = BCCC_SUP_NEG;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			class_ff <= BCCC_SUP_INVALID;
		end else begin
			class_ff <= nxt_class;
		end
	end

	assign class_out = class_ff;

	property p_class_mix;
		@(posedge clk_in) disable iff (reset_in)
		(cmp_in[1] && cmp_in[3]) |=> class_ff == BCCC_SUP_INVALID;
	endproperty
	a_class_mix: assert property (p_class_mix)
		else $error("mixed supply pair not flagged invalid");
endmodule

// file: rtl/bccc_channel.sv
`timescale 1ns/1ps
`include "bccc_defines.svh"
module bccc_channel
	import bccc_pkg::*;
(
	input wire logic clk_in, // clock
	input wire logic reset_in, // synchronous reset
	input wire logic buf_we_in, // buffer write strobe
	input wire logic bcast_we_in, // broadcast write strobe
	input wire logic [12:0] code_in, // written code
	input wire logic trig_in, // trigger event
	input wire logic sync_en_in, // synchronous update mode
	input wire logic member_in, // broadcast member
	input wire logic lim_on_in, // code limit in force
	input wire logic [5:0] lim_in, // upper six bit ceiling
	output logic [12:0] buf_out, // buffer code
	output logic [12:0] act_out // active code
);
	logic [12:0] buf_ff;
	logic [12:0] pend_ff;
	logic [12:0] act_ff;
	logic [12:0] lim_code;
	logic bc_hit;

	assign bc_hit = bcast_we_in && member_in;
	// the ceiling is applied when the code is written, never afterwards
	assign lim_code = (lim_on_in && code_in[12:7] > lim_in) ?
		{lim_in, `BCCC_LIMIT_LOW_FILL} : code_in;

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			buf_ff <= `BCCC_RST_CODE;
			pend_ff <= `BCCC_RST_CODE;
		end else if (buf_we_in || bc_hit) begin
			buf_ff <= code_in;
			pend_ff <= lim_code;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			act_ff <= `BCCC_RST_CODE;
		end else if (bc_hit) begin
			act_ff <= lim_code;
		end else if (buf_we_in && !sync_en_in) begin
			act_ff <= lim_code;
		end else if (trig_in && sync_en_in) begin
			act_ff <= pend_ff;
		end
	end

	assign buf_out = buf_ff;
	assign act_out = act_ff;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	property p_bcast;
		bc_hit |=> buf_ff == $past(code_in) && act_ff == $past(lim_code);
	endproperty
	a_bcast: assert property (p_bcast)
		else $error("broadcast did not load both registers");
	property p_buf_raw;
		buf_we_in |=> buf_ff == $past(code_in);
	endproperty
	a_buf_raw: assert property (p_buf_raw)
		else $error("buffer code was altered by the limit");
	property p_trig_copy;
		trig_in && sync_en_in && !bc_hit |=> act_ff == $past(pend_ff);
	endproperty
	a_trig_copy: assert property (p_trig_copy)
		else $error("trigger did not move the buffered code");
endmodule

// file: rtl/bccc_top.sv
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "bccc_defines.svh"
module bccc_top
	import bccc_pkg::*;
(
	input wire logic CLK_IN, // 50 mhz clock
	input wire logic RESET_IN, // synchronous reset, also power-on reset
	input wire logic [11:0] AXI_AWADDR_IN, // write address
	input wire logic AXI_AWVALID_IN, // write address valid
	output logic AXI_AWREADY_OUT, // write address ready
	input wire logic [31:0] AXI_WDATA_IN, // write data
	input wire logic [3:0] AXI_WSTRB_IN, // write byte strobes
	input wire logic AXI_WVALID_IN, // write data valid
	output logic AXI_WREADY_OUT, // write data ready
	output logic [1:0] AXI_BRESP_OUT, // write response
	output logic AXI_BVALID_OUT, // write response valid
	input wire logic AXI_BREADY_IN, // write response ready
	input wire logic [11:0] AXI_ARADDR_IN, // read address
	input wire logic AXI_ARVALID_IN, // read address valid
	output logic AXI_ARREADY_OUT, // read address ready
	output logic [31:0] AXI_RDATA_OUT, // read data
	output logic [1:0] AXI_RRESP_OUT, // read response
	output logic AXI_RVALID_OUT, // read data valid
	input wire logic AXI_RREADY_IN, // read data ready
	input wire logic [7:0] SUPPLY_CMP_IN, // supply comparators, 4 per group
	input wire logic [2:0] ALARM_IN, // supply a, supply b, reference low
	input wire logic MULTIFUNCTION_PIN_IN, // load strobe pin
	output logic [103:0] DAC_CODE_OUT, // active codes, channel 0 low
	output logic [7:0] AMP_EN_OUT, // amplifier power up per channel
	output logic [7:0] CLAMP_OUT, // negative rail clamp per channel
	output logic [1:0] CUR_MODE_OUT, // short circuit current mode
	output logic [1:0] RANGE_NEG_OUT // group range, 1 = negative
);
	logic [11:0] aw_addr_ff;
	logic [11:0] ar_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic aw_got_ff;
	logic w_got_ff;
	logic ar_got_ff;
	logic awready_ff;
	logic wready_ff;
	logic arready_ff;
	logic bvalid_ff;
	logic rvalid_ff;
	bccc_resp_t bresp_ff;
	bccc_resp_t rresp_ff;
	logic [31:0] rdata_ff;
	logic [7:0] sync_en_ff;
	logic [7:0] member_ff;
	logic [7:0] channel_power_enable_ff;
	logic [7:0] clamp_ff;
	logic [5:0] lim_ff;
	logic lim_en_ff;
	logic trig_ff;
	bccc_cur_t cur_ff;
	logic [2:0] alarm_st_ff;
	logic [2:0] apd_cfg_ff;
	logic mf_load_ff;
	logic [1:0] range_neg_ff;
	logic [2:0] start_cnt_ff;
	logic [7:0] cmp_s1_ff;
	logic [7:0] cmp_s2_ff;
	logic [2:0] al_s1_ff;
	logic [2:0] al_s2_ff;
	logic pin_s1_ff;
	logic pin_s2_ff;
	logic pin_s3_ff;
	bccc_class_t cls_a;
	bccc_class_t cls_b;
	logic [12:0] buf_q [8];
	logic [12:0] act_q [8];
	logic [7:0] buf_we;
	logic [7:0] ch_trig;
	logic wr_fire;
	logic rd_take;
	logic bcast_we;
	logic pin_trig;
	logic lim_on;
	logic rd_hit;
	logic [11:0] mux_addr;
	logic [31:0] rd_val;
	logic [31:0] wd;
	logic [2:0] al_clr;
	logic [7:0] pd_mask;
	logic [7:0] nxt_channel_power_enable;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// bus slave: address and data are held until both have arrived
	assign wr_fire = aw_got_ff && w_got_ff;
	assign rd_take = ar_got_ff && !wr_fire && !rvalid_ff;
	assign mux_addr = wr_fire ? aw_addr_ff : ar_addr_ff;
	assign wd = merge(rd_val, w_data_ff, w_strb_ff);

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			awready_ff <= 1'b0;
			aw_got_ff <= 1'b0;
			aw_addr_ff <= 12'h000;
		end else if (AXI_AWVALID_IN && awready_ff) begin
			awready_ff <= 1'b0;
			aw_got_ff <= 1'b1;
			aw_addr_ff <= AXI_AWADDR_IN;
		end else if (wr_fire) begin
			aw_got_ff <= 1'b0;
		end else if (!aw_got_ff && !bvalid_ff) begin
			awready_ff <= 1'b1;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			wready_ff <= 1'b0;
			w_got_ff <= 1'b0;
			w_data_ff <= 32'h0;
			w_strb_ff <= 4'h0;
		end else if (AXI_WVALID_IN && wready_ff) begin
			wready_ff <= 1'b0;
			w_got_ff <= 1'b1;
			w_data_ff <= AXI_WDATA_IN;
			w_strb_ff <= AXI_WSTRB_IN;
		end else if (wr_fire) begin
			w_got_ff <= 1'b0;
		end else if (!w_got_ff && !bvalid_ff) begin
			wready_ff <= 1'b1;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= BCCC_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= rd_hit ? BCCC_OKAY : BCCC_SLVERR;
		end else if (AXI_BREADY_IN) begin
			bvalid_ff <= 1'b0;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			arready_ff <= 1'b0;
			ar_got_ff <= 1'b0;
			ar_addr_ff <= 12'h000;
		end else if (AXI_ARVALID_IN && arready_ff) begin
			arready_ff <= 1'b0;
			ar_got_ff <= 1'b1;
			ar_addr_ff <= AXI_ARADDR_IN;
		end else if (rd_take) begin
			ar_got_ff <= 1'b0;
		end else if (!ar_got_ff && !rvalid_ff) begin
			arready_ff <= 1'b1;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			rvalid_ff <= 1'b0;
			rresp_ff <= BCCC_OKAY;
			rdata_ff <= 32'h0;
		end else if (rd_take) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= rd_hit ? BCCC_OKAY : BCCC_SLVERR;
			rdata_ff <= rd_val;
		end else if (AXI_RREADY_IN) begin
			rvalid_ff <= 1'b0;
		end
	end

	// one register mux serves reads and the write merge
	always_comb begin
		rd_val = 32'h0;
		rd_hit = 1'b1;
		if (mux_addr[11:5] == `BCCC_PAGE_BUF) begin
			rd_val = {19'h0, buf_q[mux_addr[4:2]]};
		end else if (mux_addr[11:5] == `BCCC_PAGE_ACT) begin
			rd_val = {19'h0, act_q[mux_addr[4:2]]};
		end else begin
			case ({mux_addr[11:2], 2'b00})
			`BCCC_OFF_BCAST: rd_val = 32'h0;
			`BCCC_OFF_TRIG: rd_val = {31'h0, trig_ff};
			`BCCC_OFF_SYNC: rd_val = {16'h0, member_ff, sync_en_ff};
			`BCCC_OFF_PWR: rd_val = {24'h0, channel_power_enable_ff};
			`BCCC_OFF_LIMIT: rd_val = {23'h0, lim_en_ff, 2'b00, lim_ff};
			`BCCC_OFF_CURR: rd_val = {30'h0, cur_ff};
			`BCCC_OFF_PSTAT: rd_val = {26'h0, cls_b, cls_a, range_neg_ff};
			`BCCC_OFF_ALARM: rd_val = {29'h0, alarm_st_ff};
			`BCCC_OFF_APD: rd_val = {29'h0, apd_cfg_ff};
			`BCCC_OFF_MFCFG: rd_val = {31'h0, mf_load_ff};
			default: rd_hit = 1'b0;
			endcase
		end
	end

	function automatic logic wr_at(input logic [11:0] off);
		return wr_fire && {aw_addr_ff[11:2], 2'b00} == off;
	endfunction

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			sync_en_ff <= 8'h00;
			member_ff <= 8'h00;
		end else if (wr_at(`BCCC_OFF_SYNC)) begin
			sync_en_ff <= wd[7:0];
			member_ff <= wd[`BCCC_SYNC_MEMBER_POS +: 8];
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			lim_ff <= `BCCC_RST_LIMIT;
			lim_en_ff <= 1'b0;
		end else if (wr_at(`BCCC_OFF_LIMIT)) begin
			lim_ff <= wd[5:0];
			lim_en_ff <= wd[`BCCC_LIMIT_EN_POS];
		end
	end
	assign lim_on = lim_en_ff && lim_ff != `BCCC_LIMIT_FULL;

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			cur_ff <= BCCC_CUR_NORMAL;
		end else if (wr_at(`BCCC_OFF_CURR) && wd[1:0] != 2'b11) begin
			cur_ff <= bccc_cur_t'(wd[1:0]);
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			apd_cfg_ff <= 3'h0;
			mf_load_ff <= 1'b0;
		end else begin
			if (wr_at(`BCCC_OFF_APD)) begin
				apd_cfg_ff <= wd[2:0];
			end
			if (wr_at(`BCCC_OFF_MFCFG)) begin
				mf_load_ff <= wd[`BCCC_MF_LOAD_POS];
			end
		end
	end

	// only set by a write, so it lasts exactly one cycle
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			trig_ff <= 1'b0;
		end else begin
			trig_ff <= wr_at(`BCCC_OFF_TRIG) && wd[`BCCC_TRIG_DAC_POS];
		end
	end

	// pins and comparators come from outside the clock domain
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			cmp_s1_ff <= 8'h00;
			cmp_s2_ff <= 8'h00;
			al_s1_ff <= 3'h0;
			al_s2_ff <= 3'h0;
			pin_s1_ff <= 1'b0;
			pin_s2_ff <= 1'b0;
			pin_s3_ff <= 1'b0;
		end else begin
			cmp_s1_ff <= SUPPLY_CMP_IN;
			cmp_s2_ff <= cmp_s1_ff;
			al_s1_ff <= ALARM_IN;
			al_s2_ff <= al_s1_ff;
			pin_s1_ff <= MULTIFUNCTION_PIN_IN;
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
		end
	end

	assign pin_trig = mf_load_ff && pin_s2_ff && !pin_s3_ff;

	// alarm set wins over a software clear in the same cycle
	assign al_clr = (wr_at(`BCCC_OFF_ALARM) && w_strb_ff[0]) ?
		w_data_ff[2:0] : 3'h0;
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			alarm_st_ff <= 3'h0;
		end else begin
			alarm_st_ff <= al_s2_ff | (alarm_st_ff & ~al_clr);
		end
	end

	// group a is channels 0-3, group b 4-7; reference alarm hits both
	assign pd_mask = {{4{(al_s2_ff[1] && apd_cfg_ff[1]) ||
		(al_s2_ff[2] && apd_cfg_ff[2])}},
		{4{(al_s2_ff[0] && apd_cfg_ff[0]) ||
		(al_s2_ff[2] && apd_cfg_ff[2])}}};
	assign nxt_channel_power_enable = (wr_at(`BCCC_OFF_PWR) ? wd[7:0] : channel_power_enable_ff) &
		~pd_mask;

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			channel_power_enable_ff <= `BCCC_RST_PWR;
			clamp_ff <= ~`BCCC_RST_PWR;
		end else begin
			channel_power_enable_ff <= nxt_channel_power_enable;
			clamp_ff <= ~nxt_channel_power_enable;
		end
	end

	bccc_supply_class u_class_a (
		.clk_in(CLK_IN),
		.reset_in(RESET_IN),
		.cmp_in(cmp_s2_ff[3:0]),
		.class_out(cls_a)
	);
	bccc_supply_class u_class_b (
		.clk_in(CLK_IN),
		.reset_in(RESET_IN),
		.cmp_in(cmp_s2_ff[7:4]),
		.class_out(cls_b)
	);

	// snapshot once the synchronised classification has settled
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			start_cnt_ff <= `BCCC_STARTUP_CYC;
			range_neg_ff <= `BCCC_RST_RANGE_NEG;
		end else if (start_cnt_ff != 3'h0) begin
			start_cnt_ff <= start_cnt_ff - 3'h1;
			if (start_cnt_ff == 3'h1) begin
				range_neg_ff <= {cls_b != BCCC_SUP_POS,
					cls_a != BCCC_SUP_POS};
			end
		end
	end

	assign bcast_we = wr_at(`BCCC_OFF_BCAST);

	for (genvar i = 0; i < 8; i++) begin : g_ch
		assign buf_we[i] = wr_fire && aw_addr_ff[11:5] == `BCCC_PAGE_BUF &&
			aw_addr_ff[4:2] == 3'(i);
		assign ch_trig[i] = trig_ff || (pin_trig && (i == 0 || i == 2));
		bccc_channel u_ch (
			.clk_in(CLK_IN),
			.reset_in(RESET_IN),
			.buf_we_in(buf_we[i]),
			.bcast_we_in(bcast_we),
			.code_in(wd[12:0]),
			.trig_in(ch_trig[i]),
			.sync_en_in(sync_en_ff[i]),
			.member_in(member_ff[i]),
			.lim_on_in(lim_on),
			.lim_in(lim_ff),
			.buf_out(buf_q[i]),
			.act_out(act_q[i])
		);
		// unsigned code straight to the converter, no recoding
		assign DAC_CODE_OUT[13*i +: 13] = act_q[i];
	end

	assign AXI_AWREADY_OUT = awready_ff;
	assign AXI_WREADY_OUT = wready_ff;
	assign AXI_BRESP_OUT = bresp_ff;
	assign AXI_BVALID_OUT = bvalid_ff;
	assign AXI_ARREADY_OUT = arready_ff;
	assign AXI_RDATA_OUT = rdata_ff;
	assign AXI_RRESP_OUT = rresp_ff;
	assign AXI_RVALID_OUT = rvalid_ff;
	assign AMP_EN_OUT = channel_power_enable_ff;
	assign CLAMP_OUT = clamp_ff;
	assign CUR_MODE_OUT = cur_ff;
	assign RANGE_NEG_OUT = range_neg_ff;

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RESET_IN);

	property p_reset;
		$fell(RESET_IN) |-> AMP_EN_OUT == 8'h00 && CLAMP_OUT == 8'hff &&
			DAC_CODE_OUT == 104'h0;
	endproperty
	a_reset: assert property (p_reset)
		else $error("reset left outputs enabled or codes nonzero");
	property p_clamp;
		CLAMP_OUT == ~AMP_EN_OUT;
	endproperty
	a_clamp: assert property (p_clamp)
		else $error("clamp does not mirror amplifier power");
	property p_pwr_write;
		wr_at(`BCCC_OFF_PWR) && pd_mask == 8'h00 |=>
			AMP_EN_OUT == $past(wd[7:0]);
	endproperty
	a_pwr_write: assert property (p_pwr_write)
		else $error("power enable write not applied");
	property p_alarm_pd;
		pd_mask[0] |=> !AMP_EN_OUT[0] && CLAMP_OUT[0];
	endproperty
	a_alarm_pd: assert property (p_alarm_pd)
		else $error("alarm did not power the channel down");
	property p_trig_pulse;
		trig_ff |=> !trig_ff;
	endproperty
	a_trig_pulse: assert property (p_trig_pulse)
		else $error("trigger bit did not self clear");
	property p_async;
		buf_we[1] && !sync_en_ff[1] && !lim_on |=>
			DAC_CODE_OUT[25:13] == $past(wd[12:0]);
	endproperty
	a_async: assert property (p_async)
		else $error("asynchronous channel not updated");
	property p_sync_hold;
		buf_we[1] && sync_en_ff[1] && !ch_trig[1] && !bcast_we |=>
			$stable(DAC_CODE_OUT[25:13]);
	endproperty
	a_sync_hold: assert property (p_sync_hold)
		else $error("synchronous channel changed without trigger");
	property p_pin_only;
		pin_trig && !trig_ff |-> !ch_trig[1] && ch_trig[0] && ch_trig[2];
	endproperty
	a_pin_only: assert property (p_pin_only)
		else $error("load strobe reached the wrong channels");
	property p_limit;
		buf_we[3] && lim_on && !sync_en_ff[3] |=>
			DAC_CODE_OUT[51:46] <= $past(lim_ff);
	endproperty
	a_limit: assert property (p_limit)
		else $error("active code exceeds the ceiling");
	property p_alarm_set;
		al_s2_ff[2] |=> alarm_st_ff[2] ##1
			(alarm_st_ff[2] || $past(al_clr[2]));
	endproperty
	a_alarm_set: assert property (p_alarm_set)
		else $error("reference alarm not held sticky");
	property p_cur;
		wr_at(`BCCC_OFF_CURR) && wd[1:0] != 2'b11 |=>
			CUR_MODE_OUT == $past(wd[1:0]);
	endproperty
	a_cur: assert property (p_cur)
		else $error("current mode write not applied");
	property p_range;
		start_cnt_ff == 3'h0 |=> $stable(RANGE_NEG_OUT);
	endproperty
	a_range: assert property (p_range)
		else $error("range changed after startup");

	c_wr_resp: cover property (wr_fire ##1 AXI_BVALID_OUT && AXI_BREADY_IN);
	c_reg_trig: cover property (trig_ff && sync_en_ff != 8'h00);
	c_pin_trig: cover property (pin_trig && sync_en_ff[0]);
	c_alarm_pd: cover property (pd_mask != 8'h00 && channel_power_enable_ff != 8'h00);
endmodule

// file: sim/tb_bccc_top.sv
`timescale 1ns/1ps
`include "bccc_defines.svh"
module tb_bccc_top;
	import bccc_pkg::*;
	logic clk = 1'b0, rst = 1'b1, pin = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [11:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, rv;
	logic [1:0] bresp, rresp, rs, cur, rng;
	logic [7:0] cmp = 8'h96, amp, clamp;
	logic [2:0] alarm = '0;
	logic [103:0] dco;
	int errors = 0;
	int checked = 0;

	bccc_top bccc_top_i (
		.CLK_IN(clk),
		.RESET_IN(rst),
		.AXI_AWADDR_IN(awaddr),
		.AXI_AWVALID_IN(awvalid),
		.AXI_AWREADY_OUT(awready),
		.AXI_WDATA_IN(wdata),
		.AXI_WSTRB_IN(4'hf),
		.AXI_WVALID_IN(wvalid),
		.AXI_WREADY_OUT(wready),
		.AXI_BRESP_OUT(bresp),
		.AXI_BVALID_OUT(bvalid),
		.AXI_BREADY_IN(bready),
		.AXI_ARADDR_IN(araddr),
		.AXI_ARVALID_IN(arvalid),
		.AXI_ARREADY_OUT(arready),
		.AXI_RDATA_OUT(rdata),
		.AXI_RRESP_OUT(rresp),
		.AXI_RVALID_OUT(rvalid),
		.AXI_RREADY_IN(rready),
		.SUPPLY_CMP_IN(cmp),
		.ALARM_IN(alarm),
		.MULTIFUNCTION_PIN_IN(pin),
		.DAC_CODE_OUT(dco),
		.AMP_EN_OUT(amp),
		.CLAMP_OUT(clamp),
		.CUR_MODE_OUT(cur),
		.RANGE_NEG_OUT(rng)
	);

	always #10 clk = ~clk;

	task automatic close_out();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask

	task automatic tmo(input int n);
		if (n >= 64) begin
			errors++;
			close_out();
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 64);
		rs = bresp;
		bready <= 1'b0;
		tmo(n);
		@(posedge clk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		int n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 64);
		rv = rdata;
		rs = rresp;
		rready <= 1'b0;
		tmo(n);
		@(posedge clk);
		chk("rd", rv, e);
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("code", 32'(dco !== '0), 32'h0);
		chk("amp", amp, 8'h00);
		chk("clamp", clamp, 8'hff);
		cyc(4);
		chk("rng", rng, 2'h2);
		rd(`BCCC_OFF_PSTAT, 32'h26);
		cmp <= 8'h9a;
		cyc(4);
		rd(`BCCC_OFF_PSTAT, 32'h22);
		wr(`BCCC_OFF_PWR, 32'ha5);
		chk("amp", amp, 8'ha5);
		chk("clamp", clamp, 8'h5a);
		for (int i = 0; i < 8; i++) begin
			wr(12'(4 * i), 32'h1fff - 32'(i));
			chk("act", 32'(dco[13 * i +: 13]), 32'h1fff - 32'(i));
			rd(12'(32 + 4 * i), 32'h1fff - 32'(i));
		end
		wr(`BCCC_OFF_SYNC, 32'h05);
		wr(12'h000, 32'h0111);
		chk("sy0", 32'(dco[12:0]), 32'h1fff);
		rd(12'h000, 32'h0111);
		wr(`BCCC_OFF_TRIG, 32'h1);
		chk("tr0", 32'(dco[12:0]), 32'h0111);
		rd(`BCCC_OFF_TRIG, 32'h0);
		wr(`BCCC_OFF_MFCFG, 32'h1);
		wr(`BCCC_OFF_SYNC, 32'h07);
		wr(12'h000, 32'h0222);
		wr(12'h004, 32'h0333);
		wr(12'h008, 32'h0444);
		pin <= 1'b1;
		cyc(5);
		pin <= 1'b0;
		chk("pn0", 32'(dco[12:0]), 32'h0222);
		chk("pn1", 32'(dco[25:13]), 32'h1ffe);
		chk("pn2", 32'(dco[38:26]), 32'h0444);
		wr(`BCCC_OFF_TRIG, 32'h1);
		chk("tr1", 32'(dco[25:13]), 32'h0333);
		wr(`BCCC_OFF_SYNC, 32'h8101);
		wr(`BCCC_OFF_BCAST, 32'h0abc);
		chk("bc0", 32'(dco[12:0]), 32'h0abc);
		chk("bc7", 32'(dco[103:91]), 32'h0abc);
		chk("bc3", 32'(dco[51:39]), 32'h1ffc);
		rd(12'h01c, 32'h0abc);
		wr(`BCCC_OFF_SYNC, 32'h0);
		// ceiling programmed ahead of the codes it caps
		wr(`BCCC_OFF_LIMIT, 32'h110);
		chk("kp3", 32'(dco[51:39]), 32'h1ffc);
		wr(12'h00c, 32'h1fff);
		chk("lm3", 32'(dco[51:39]), 32'h087f);
		rd(12'h00c, 32'h1fff);
		wr(12'h010, 32'h0800);
		chk("lm4", 32'(dco[64:52]), 32'h0800);
		for (int m = 0; m < 4; m++) begin
			wr(`BCCC_OFF_CURR, 32'(m));
			chk("cur", 32'(cur), m == 3 ? 32'h2 : 32'(m));
		end
		wr(`BCCC_OFF_APD, 32'h1);
		alarm <= 3'h7;
		cyc(5);
		chk("apd", amp, 8'ha0);
		chk("apc", clamp, 8'h5f);
		alarm <= 3'h0;
		cyc(4);
		rd(`BCCC_OFF_PWR, 32'ha0);
		rd(`BCCC_OFF_ALARM, 32'h7);
		wr(`BCCC_OFF_ALARM, 32'h7);
		rd(`BCCC_OFF_ALARM, 32'h0);
		wr(`BCCC_OFF_PWR, 32'hff);
		chk("ren", amp, 8'hff);
		wr(12'h0f0, 32'h1);
		chk("brs", rs, BCCC_SLVERR);
		rd(12'h0f0, 32'h0);
		chk("rrs", rs, BCCC_SLVERR);
		rst <= 1'b1;
		cyc(2);
		rst <= 1'b0;
		@(posedge clk);
		chk("rcd", 32'(dco !== '0), 32'h0);
		chk("ram", amp, 8'h00);
		cyc(4);
		chk("rg2", rng, 2'h3);
		rd(`BCCC_OFF_LIMIT, 32'h03f);
		close_out();
	end
endmodule
